// *** logic/hba_ctrl.sv ***
// Host-side configuration controller for a pipelined host bus arbiter.
// Software reaches it over classic Wishbone; the device sees a req/ack
// write port and a stream of legal bridge transfer pieces.
`default_nettype none
`timescale 1ns/1ns

module hba_ctrl import hba_pkg::*; (
   input  wire logic         mclk_i,
   input  wire logic         rst_b_i,
   input  wire logic         ce_i,
   input  wire logic         wb_cyc_i,
   input  wire logic         wb_stb_i,
   input  wire logic         wb_we_i,
   input  wire logic [7:0]   wb_adr_i,
   input  wire logic [3:0]   wb_sel_i,
   input  wire logic [31:0]  wb_dat_i,
   output logic [31:0]       wb_dat_o,
   output logic              wb_ack_o,
   output hba_cfg_bus_t      cfg_o,
   input  wire logic         cfg_ack_i,
   input  wire hba_xfer_t    xfer_i,
   input  wire logic         xfer_valid_i,
   output logic              xfer_ready_o,
   output hba_piece_t        piece_o,
   output logic              piece_valid_o,
   input  wire logic         piece_ready_i
);
   logic [31:0] config_q;
   logic [31:0] system_q;
   logic [31:0] arb_out;
   logic [31:0] cs_out;
   logic        hazard;
   logic        odd_seen;
   logic        fixed;
   logic        push_busy;
   logic        acc;
   logic        wr;
   logic        push;
   logic        odd_pulse;
   logic        follow;
   logic        piece_take;
   logic        hazard_set;
   logic [31:0] next_arb;
   logic [31:0] next_cs;
   logic        next_fixed;
   logic [31:0] next_rdata;
   logic [31:0] req_arb;
   logic [31:0] req_cs;

   function automatic logic [31:0] hba_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[8*b +: 8] = wd[8*b +: 8];
         end
      end
      return r;
   endfunction

   // ==========================================================
   // Wishbone slave: ack one cycle after the strobe is seen
   assign acc  = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr   = acc && wb_we_i;
   assign push = ce_i && wr && (wb_adr_i == ADR_COMMAND) && wb_sel_i[0] &&
                 wb_dat_i[CMD_PUSH] && !push_busy;

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wb_ack_o <= 1'b0;
      end else if (ce_i) begin
         wb_ack_o <= acc;
      end
   end

   always_comb begin
      next_rdata = '0;
      unique case (wb_adr_i)
         ADR_CONFIG:  next_rdata = config_q;
         ADR_SYSTEM:  next_rdata = system_q;
         ADR_STATUS:  begin
            next_rdata[ST_BUSY]   = push_busy;
            next_rdata[ST_HAZARD] = hazard;
            next_rdata[ST_ODD]    = odd_seen;
            next_rdata[ST_FIXED]  = fixed;
         end
         ADR_ARB_OUT: next_rdata = arb_out;
         ADR_CS_OUT:  next_rdata = cs_out;
         default:     next_rdata = '0;
      endcase
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wb_dat_o <= '0;
      end else if (ce_i && acc) begin
         wb_dat_o <= next_rdata;
      end
   end

   // ==========================================================
   // Software-facing settings
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         config_q <= CONFIG_RST;
         system_q <= SYSTEM_RST;
      end else if (ce_i && wr) begin
         if (wb_adr_i == ADR_CONFIG) begin
            config_q <= hba_merge(config_q, wb_dat_i, wb_sel_i);
         end
         if (wb_adr_i == ADR_SYSTEM) begin
            system_q <= hba_merge(system_q, wb_dat_i, wb_sel_i);
         end
      end
   end

   // ==========================================================
   // Legalise requested settings before they reach the device
   always_comb begin
      logic [2:0] depth;
      logic [1:0] read_turnoff_field;
      logic [4:0] ws;
      logic       en;
      logic       ddg;
      logic       reduced_setup_time;
      logic       rsd;
      depth   = config_q[ARB_DEPTH_LSB +: 3];
      read_turnoff_field    = config_q[CFG_CS_LSB + CS_READ_TURNOFF_FIELD_LSB +: 2];
      ws      = config_q[CFG_CS_LSB + CS_WS_LSB +: 5];
      en      = config_q[ARB_EN];
      ddg     = config_q[ARB_DDG];
      reduced_setup_time    = config_q[ARB_REDUCED_SETUP_TIME];
      rsd     = config_q[ARB_RSD];
      req_arb = {23'h0, config_q[ARB_DDG:0]};
      req_cs  = {25'h0, config_q[CFG_CS_LSB +: 7]};
      // Never hand the device a reserved depth code
      if (depth != DEPTH_FOUR && depth != DEPTH_ONE && depth != DEPTH_TWO) begin
         depth = DEPTH_ONE;
      end
      if (en) begin
         if (system_q[SYS_LATE]) begin
            ddg = 1'b1;
         end else if (system_q[SYS_EXT_ARB]) begin
            en = 1'b0;
         end else begin
            depth = DEPTH_ONE;
         end
      end
      if (depth == DEPTH_FOUR) begin
         rsd = 1'b1;
      end
      if (system_q[SYS_NRSDRAM]) begin
         reduced_setup_time = 1'b1;
      end
      if (system_q[SYS_ASRAM]) begin
         read_turnoff_field = READ_TURNOFF_FIELD_ZERO;
         if (!reduced_setup_time && ws == WS_NONE) begin
            ws = WS_ONE;
         end
      end
      next_arb = req_arb;
      next_arb[ARB_DEPTH_LSB +: 3] = depth;
      next_arb[ARB_EN]   = en;
      next_arb[ARB_DDG]  = ddg;
      next_arb[ARB_REDUCED_SETUP_TIME] = reduced_setup_time;
      next_arb[ARB_RSD]  = rsd;
      next_cs = '0;
      next_cs[CS_READ_TURNOFF_FIELD_LSB +: 2] = read_turnoff_field;
      next_cs[CS_WS_LSB +: 5]   = ws;
      next_fixed = (next_arb != req_arb) || (next_cs != req_cs);
   end

   // Words held so software can read back what was sent
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         arb_out <= '0;
         cs_out  <= '0;
         fixed   <= 1'b0;
      end else if (push) begin
         arb_out <= next_arb;
         cs_out  <= next_cs;
         fixed   <= next_fixed;
      end
   end

   // ==========================================================
   // Sticky status; a set in the clearing cycle wins
   assign piece_take = ce_i && piece_valid_o && piece_ready_i;
   assign hazard_set = piece_take && follow && arb_out[ARB_EN] &&
                       arb_out[ARB_DEPTH_LSB +: 3] == DEPTH_ONE &&
                       !arb_out[ARB_DDG];

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         hazard   <= 1'b0;
         odd_seen <= 1'b0;
      end else if (ce_i) begin
         if (hazard_set) begin
            hazard <= 1'b1;
         end else if (wr && wb_adr_i == ADR_STATUS && wb_sel_i[0] &&
                      wb_dat_i[ST_HAZARD]) begin
            hazard <= 1'b0;
         end
         if (odd_pulse) begin
            odd_seen <= 1'b1;
         end else if (wr && wb_adr_i == ADR_STATUS && wb_sel_i[0] &&
                      wb_dat_i[ST_ODD]) begin
            odd_seen <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Sub-blocks
   hba_cfg_push u_push (
      .mclk_i     (mclk_i),
      .rst_b_i    (rst_b_i),
      .ce_i       (ce_i),
      .start_i    (push),
      .arb_word_i (next_arb),
      .cs_word_i  (next_cs),
      .cfg_ack_i  (cfg_ack_i),
      .busy_o     (push_busy),
      .cfg_o      (cfg_o)
   );

   hba_xfer_split u_split (
      .mclk_i        (mclk_i),
      .rst_b_i       (rst_b_i),
      .ce_i          (ce_i),
      .req_i         (xfer_i),
      .req_valid_i   (xfer_valid_i),
      .req_ready_o   (xfer_ready_o),
      .piece_o       (piece_o),
      .piece_valid_o (piece_valid_o),
      .piece_ready_i (piece_ready_i),
      .follow_o      (follow),
      .odd_o         (odd_pulse)
   );

   // ==========================================================
   // Checks
   depth_rsd_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      cfg_o.req && cfg_o.sel == SEL_ARB &&
      cfg_o.data[ARB_DEPTH_LSB +: 3] == DEPTH_FOUR |-> cfg_o.data[ARB_RSD])
      else $error("depth four sent without reduced slave depth");

   asram_wait_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      push && system_q[SYS_ASRAM] |=>
      arb_out[ARB_REDUCED_SETUP_TIME] || cs_out[CS_WS_LSB +: 5] != WS_NONE)
      else $error("async SRAM with no wait state");

   sdram_setup_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      push && system_q[SYS_NRSDRAM] |=> arb_out[ARB_REDUCED_SETUP_TIME])
      else $error("setup bit clear for plain SDRAM");

   asram_read_turnoff_field_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      push && system_q[SYS_ASRAM] |=> cs_out[CS_READ_TURNOFF_FIELD_LSB +: 2] == READ_TURNOFF_FIELD_ZERO)
      else $error("async SRAM with nonzero turn-off");

   late_grant_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      push && config_q[ARB_EN] && system_q[SYS_LATE] |=>
      arb_out[ARB_DDG] && arb_out[ARB_EN])
      else $error("late silicon without delayed data grant");

   early_depth_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      push && config_q[ARB_EN] && !system_q[SYS_LATE] && !system_q[SYS_EXT_ARB]
      |=> arb_out[ARB_EN] && arb_out[ARB_DEPTH_LSB +: 3] == DEPTH_ONE)
      else $error("workaround depth not applied");

   ext_arb_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      push && config_q[ARB_EN] && !system_q[SYS_LATE] && system_q[SYS_EXT_ARB]
      |=> !arb_out[ARB_EN])
      else $error("internal arbiter left on");

   hazard_flag_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      hazard_set |=> hazard)
      else $error("hang risk not flagged");

   odd_flag_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      ce_i && odd_pulse |=> odd_seen)
      else $error("odd request not flagged");

   push_send_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      push |=> cfg_o.req && cfg_o.sel == SEL_ARB && cfg_o.data == arb_out)
      else $error("pushed word not sent");
endmodule // hba_ctrl
`default_nettype wire

// *** logic/hba_pkg.sv ***
// Constants and carriers for the host-bus arbiter configuration controller.
// Assumes one 100 MHz clock shared by every module that imports it.
`default_nettype none
package hba_pkg;
   // ==========================================================
   // Own register map, byte addresses on classic Wishbone
   localparam logic [7:0] ADR_CONFIG  = 8'h00;
   localparam logic [7:0] ADR_SYSTEM  = 8'h04;
   localparam logic [7:0] ADR_COMMAND = 8'h08;
   localparam logic [7:0] ADR_STATUS  = 8'h0c;
   localparam logic [7:0] ADR_ARB_OUT = 8'h10;
   localparam logic [7:0] ADR_CS_OUT  = 8'h14;
   localparam logic [31:0] CONFIG_RST = 32'h0000_0000;
   localparam logic [31:0] SYSTEM_RST = 32'h0000_0000;
   // ==========================================================
   // Arbiter control word fields
   localparam int ARB_DEPTH_LSB = 0;
   localparam int ARB_IDLE_DG   = 3;
   localparam int ARB_RSD       = 4;
   localparam int ARB_MODE      = 5;
   localparam int ARB_EN        = 6;
   localparam int ARB_REDUCED_SETUP_TIME      = 7;
   localparam int ARB_DDG       = 8;
   localparam logic [2:0] DEPTH_FOUR = 3'h0;
   localparam logic [2:0] DEPTH_ONE  = 3'h1;
   localparam logic [2:0] DEPTH_TWO  = 3'h2;
   // ==========================================================
   // Chip-select mask word fields
   localparam int CS_READ_TURNOFF_FIELD_LSB = 0;
   localparam int CS_WS_LSB   = 2;
   localparam int CFG_CS_LSB  = 16;
   localparam logic [1:0] READ_TURNOFF_FIELD_ZERO = 2'h0;
   localparam logic [4:0] WS_NONE   = 5'h00;
   localparam logic [4:0] WS_ONE    = 5'h01;
   // ==========================================================
   // System, command and status bits
   localparam int SYS_ASRAM   = 0;
   localparam int SYS_NRSDRAM = 1;
   localparam int SYS_LATE    = 2;
   localparam int SYS_EXT_ARB = 3;
   localparam int CMD_PUSH    = 0;
   localparam int ST_BUSY     = 0;
   localparam int ST_HAZARD   = 1;
   localparam int ST_ODD      = 2;
   localparam int ST_FIXED    = 3;
   // ==========================================================
   // Host bus transfer sizes and config word selects
   localparam logic [5:0] BEAT_BYTES  = 6'h08;
   localparam logic [5:0] BURST_BYTES = 6'h20;
   localparam logic       SEL_ARB     = 1'b0;
   localparam logic       SEL_CS      = 1'b1;

   typedef struct packed {
      logic        req;
      logic        sel;
      logic [31:0] data;
   } hba_cfg_bus_t;

   typedef struct packed {
      logic [31:0] addr;
      logic [5:0]  len;
   } hba_xfer_t;

   typedef struct packed {
      logic [31:0] addr;
      logic [5:0]  size;
      logic        burst;
   } hba_piece_t;
endpackage
`default_nettype wire

// *** logic/hba_cfg_push.sv ***
// Writes the arbiter word, then the chip-select word, to the device.
// Assumes a four-phase req/ack on device pins; ack arrives asynchronously.
`default_nettype none
`timescale 1ns/1ns
module hba_cfg_push import hba_pkg::*; (
   input  wire logic         mclk_i,
   input  wire logic         rst_b_i,
   input  wire logic         ce_i,
   input  wire logic         start_i,
   input  wire logic [31:0]  arb_word_i,
   input  wire logic [31:0]  cs_word_i,
   input  wire logic         cfg_ack_i,
   output logic              busy_o,
   output hba_cfg_bus_t      cfg_o
);
   typedef enum logic [2:0] {
      HBA_IDLE, HBA_SEND_ARB, HBA_LOW_ARB, HBA_SEND_CS, HBA_LOW_CS
   } hba_push_st_t;

   hba_push_st_t state;
   logic         ack_meta;
   logic         ack_s;

   // ==========================================================
   // Ack synchroniser
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ack_meta <= 1'b0;
         ack_s    <= 1'b0;
      end else if (ce_i) begin
         ack_meta <= cfg_ack_i;
         ack_s    <= ack_meta;
      end
   end

   // ==========================================================
   // Sequencer; request held until ack seen, then ack must fall
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state <= HBA_IDLE;
         cfg_o <= '0;
      end else if (ce_i) begin
         unique case (state)
            HBA_IDLE: if (start_i) begin
               state <= HBA_SEND_ARB;
               cfg_o <= '{req: 1'b1, sel: SEL_ARB, data: arb_word_i};
            end
            HBA_SEND_ARB: if (ack_s) begin
               state     <= HBA_LOW_ARB;
               cfg_o.req <= 1'b0;
            end
            HBA_LOW_ARB: if (!ack_s) begin
               state <= HBA_SEND_CS;
               cfg_o <= '{req: 1'b1, sel: SEL_CS, data: cs_word_i};
            end
            HBA_SEND_CS: if (ack_s) begin
               state     <= HBA_LOW_CS;
               cfg_o.req <= 1'b0;
            end
            HBA_LOW_CS: if (!ack_s) begin
               state <= HBA_IDLE;
            end
         endcase
      end
   end

   assign busy_o = (state != HBA_IDLE);

   req_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      cfg_o.req && !ack_s |=> cfg_o.req && $stable(cfg_o.data))
      else $error("config request dropped before ack");
endmodule // hba_cfg_push
`default_nettype wire

// *** logic/hba_xfer_split.sv ***
// Splits bridge requests into singles inside one 8-byte lane or aligned 32-byte bursts.
// Assumes requests and piece ready come from logic on mclk_i.
`default_nettype none
`timescale 1ns/1ns
module hba_xfer_split import hba_pkg::*; (
   input  wire logic   mclk_i,
   input  wire logic   rst_b_i,
   input  wire logic   ce_i,
   input  wire hba_xfer_t req_i,
   input  wire logic   req_valid_i,
   output logic        req_ready_o,
   output hba_piece_t  piece_o,
   output logic        piece_valid_o,
   input  wire logic   piece_ready_i,
   output logic        follow_o,
   output logic        odd_o
);
   logic        active;
   logic        first;
   logic [31:0] cur_addr;
   logic [5:0]  remain;
   logic [5:0]  room;
   logic [5:0]  next_size;
   logic        next_burst;
   logic        load;

   assign req_ready_o = !active;
   assign load        = active && (!piece_valid_o || piece_ready_i);
   assign room        = BEAT_BYTES - {3'h0, cur_addr[2:0]};
   assign next_burst  = (cur_addr[4:0] == 5'h00) && (remain == BURST_BYTES);
   // Singles never cross an 8-byte lane; larger or ragged requests become singles, save a 32-aligned final 32 bytes, which go as a burst
   assign next_size   = next_burst ? BURST_BYTES :
                        (remain < room) ? remain : room;

   // ==========================================================
   // Request walker
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         active   <= 1'b0;
         first    <= 1'b0;
         cur_addr <= '0;
         remain   <= '0;
         odd_o    <= 1'b0;
      end else if (ce_i) begin
         odd_o <= 1'b0;
         if (!active && req_valid_i) begin
            active   <= (req_i.len != 6'h00);
            first    <= 1'b1;
            cur_addr <= req_i.addr;
            remain   <= req_i.len;
            odd_o    <= !(((req_i.len == BEAT_BYTES) && (req_i.addr[2:0] == 3'h0)) ||
                          ((req_i.len == BURST_BYTES) && (req_i.addr[4:0] == 5'h00)));
         end else if (load) begin
            first    <= 1'b0;
            cur_addr <= cur_addr + {26'h0, next_size};
            remain   <= remain - next_size;
            active   <= (remain != next_size);
         end
      end
   end

   // ==========================================================
   // Piece output register
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         piece_o       <= '0;
         piece_valid_o <= 1'b0;
         follow_o      <= 1'b0;
      end else if (ce_i) begin
         if (load) begin
            piece_o       <= '{addr: cur_addr, size: next_size, burst: next_burst};
            piece_valid_o <= 1'b1;
            follow_o      <= !first;
         end else if (piece_ready_i) begin
            piece_valid_o <= 1'b0;
         end
      end
   end

   piece_shape_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      piece_valid_o |-> (piece_o.burst && piece_o.size == BURST_BYTES &&
                         piece_o.addr[4:0] == 5'h00) ||
                        (!piece_o.burst && piece_o.size != 6'h00 &&
                         ({3'h0, piece_o.addr[2:0]} + piece_o.size) <= BEAT_BYTES))
      else $error("piece not aligned single or burst");
endmodule // hba_xfer_split
`default_nettype wire

// *** bench/hba_dev_model.sv ***
// Behavioural device at the far side: config word port and piece sink.
// Assumes the controller's req/ack link and piece stream on mclk_i.
`timescale 1ns/1ns
`default_nettype none
module hba_dev_model import hba_pkg::*; (
   input  wire logic          mclk_i,
   input  wire logic          rst_b_i,
   input  wire logic          slow_i,
   input  wire hba_cfg_bus_t  cfg_i,
   input  wire logic          piece_valid_i,
   output logic               cfg_ack_o,
   output logic               piece_ready_o,
   output logic [31:0]        arb_o,
   output logic [31:0]        cs_o
);
   // ==========================================================
   // Config link, four-phase, slow mode stretches the answer
   logic [1:0] cnt;
   logic       tog;
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cfg_ack_o <= 1'b0;
         cnt       <= 2'h0;
         arb_o     <= 32'h0;
         cs_o      <= 32'h0;
      end else if (cfg_i.req && !cfg_ack_o) begin
         if (cnt == (slow_i ? 2'h3 : 2'h0)) begin
            cfg_ack_o <= 1'b1;
            cnt       <= 2'h0;
            if (cfg_i.sel == SEL_CS) begin
               cs_o <= cfg_i.data;
            end else begin
               arb_o <= cfg_i.data;
            end
         end else begin
            cnt <= cnt + 2'h1;
         end
      end else if (!cfg_i.req) begin
         cfg_ack_o <= 1'b0;
      end
   end
   // ==========================================================
   // Piece sink stalls every other cycle in slow mode
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tog <= 1'b0;
      end else begin
         tog <= ~tog;
      end
   end
   // ==========================================================
   // Outstanding tenures; each data phase retires one cycle later
   logic [2:0] pend;
   logic [2:0] depth_lim;
   logic       take;
   assign take      = piece_valid_i && piece_ready_o;
   assign depth_lim = (arb_o[2:0] == DEPTH_TWO)  ? 3'h2 :
                      (arb_o[2:0] == DEPTH_FOUR) ? 3'h4 : 3'h1;
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pend <= 3'h0;
      end else begin
         pend <= pend + {2'h0, take} - {2'h0, (pend != 3'h0)};
      end
   end
   // No further grant while outstanding count is at the depth
   assign piece_ready_o = (!slow_i || tog) && (pend < depth_lim);
endmodule // hba_dev_model
`default_nettype wire

// *** bench/testbench.sv ***
// Self-checking bench for the host-bus arbiter controller.
// Assumes the device model beside it; ce_i is held high.
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import hba_pkg::*;
   logic         mclk_i = 1'b0;
   logic         rst_b_i = 1'b0;
   logic         cyc = 1'b0;
   logic         stb = 1'b0;
   logic         we = 1'b0;
   logic [7:0]   adr = 8'h00;
   logic [31:0]  dat = 32'h0;
   logic         slow = 1'b0;
   logic         xvalid = 1'b0;
   hba_xfer_t    xreq = '0;
   logic [31:0]  wb_dat_o, arb, cs;
   logic         wb_ack_o, ack, xfer_ready_o, piece_valid_o, pready;
   hba_cfg_bus_t cfg;
   hba_piece_t   piece;
   hba_piece_t   pq[$];
   int           num_errors = 0;
   int           num_checks = 0;
   int           cycles = 0;
   always #5 mclk_i = ~mclk_i;

   hba_ctrl hba_ctrl_inst (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .ce_i(1'b1),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
      .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cfg_o(cfg),
      .cfg_ack_i(ack), .xfer_i(xreq), .xfer_valid_i(xvalid), .xfer_ready_o(xfer_ready_o),
      .piece_o(piece), .piece_valid_o(piece_valid_o), .piece_ready_i(pready));
   hba_dev_model hba_dev_model_inst (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .slow_i(slow),
      .cfg_i(cfg), .piece_valid_i(piece_valid_o), .cfg_ack_o(ack), .piece_ready_o(pready),
      .arb_o(arb), .cs_o(cs));

   // ==========================================================
   // Shared tasks
   task automatic complete_run();
      if (num_errors == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk32(input string what, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic chkp(input hba_piece_t e, input hba_piece_t g);
      num_checks++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH piece expected %h seen %h", e, g);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      int n;
      n = 0;
      @(posedge mclk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      dat <= d;
      do begin
         @(posedge mclk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 100);
      q = wb_dat_o;
      if (wb_ack_o !== 1'b1) begin
         num_errors++;
         complete_run();
      end
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic cfg_case(input logic [31:0] c, s, ea, ec);
      logic [31:0] q;
      int n;
      wb(1'b1, ADR_CONFIG, c, q);
      wb(1'b1, ADR_SYSTEM, s, q);
      wb(1'b1, ADR_COMMAND, 32'h1, q);
      n = 0;
      do begin
         wb(1'b0, ADR_STATUS, 32'h0, q);
         n++;
      end while (q[ST_BUSY] !== 1'b0 && n < 50);
      chk32("fixed flag", {31'h0, (ea != (c & 32'h1ff)) || (ec != ((c >> 16) & 32'h7f))},
            {31'h0, q[ST_FIXED]});
      wb(1'b0, ADR_ARB_OUT, 32'h0, q);
      chk32("arb word", ea, q & 32'h1ff);
      chk32("device arb", ea, arb & 32'h1ff);
      wb(1'b0, ADR_CS_OUT, 32'h0, q);
      chk32("cs word", ec, q);
      chk32("device cs", ec, cs & 32'h7f);
   endtask
   task automatic xfer(input logic [31:0] a, input logic [5:0] l, input int np,
                       input logic [31:0] st);
      int n;
      logic [31:0] q;
      pq.delete();
      @(posedge mclk_i);
      xreq   <= '{addr: a, len: l};
      xvalid <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk_i);
         n++;
      end while (xfer_ready_o !== 1'b1 && n < 100);
      xvalid <= 1'b0;
      n = 0;
      while (pq.size() < np && n < 200) begin
         @(posedge mclk_i);
         n++;
      end
      chk32("piece count", np, pq.size());
      wb(1'b0, ADR_STATUS, 32'h0, q);
      chk32("status flags", st, q & 32'h6);
      wb(1'b1, ADR_STATUS, 32'h6, q);
   endtask
   always @(posedge mclk_i) begin
      if (piece_valid_o === 1'b1 && pready === 1'b1) pq.push_back(piece);
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         complete_run();
      end
   end

   // ==========================================================
   // Main sequence
   initial begin
      logic [31:0] q;
      logic [7:0]  ra [6];
      ra = '{ADR_CONFIG, ADR_SYSTEM, ADR_STATUS, ADR_ARB_OUT, ADR_CS_OUT, 8'h20};
      repeat (4) @(posedge mclk_i);
      rst_b_i <= 1'b1;
      wb(1'b1, 8'h20, 32'hffff_ffff, q);
      foreach (ra[i]) begin
         wb(1'b0, ra[i], 32'h0, q);
         chk32("reset value", 32'h0, q);
      end
      cfg_case(32'h0, 32'h0, 32'h10, 32'h0);
      cfg_case(32'h3, 32'h0, 32'h1, 32'h0);
      cfg_case(32'h6, 32'h0, 32'h1, 32'h0);
      cfg_case(32'h2a, 32'h0, 32'h2a, 32'h0);
      cfg_case(32'h12, 32'h2, 32'h92, 32'h0);
      cfg_case(32'h30011, 32'h1, 32'h11, 32'h4);
      cfg_case(32'h30091, 32'h1, 32'h91, 32'h0);
      cfg_case(32'he0001, 32'h0, 32'h1, 32'he);
      slow <= 1'b1;
      cfg_case(32'h40, 32'h8, 32'h10, 32'h0);
      slow <= 1'b0;
      cfg_case(32'h40, 32'h0, 32'h41, 32'h0);
      xfer(32'h0, 6'h10, 2, 32'h6);
      chkp('{addr: 32'h0, size: 6'h8, burst: 1'b0}, pq[0]);
      chkp('{addr: 32'h8, size: 6'h8, burst: 1'b0}, pq[1]);
      xfer(32'h20, 6'h20, 1, 32'h0);
      chkp('{addr: 32'h20, size: 6'h20, burst: 1'b1}, pq[0]);
      slow <= 1'b1;
      xfer(32'h1, 6'h8, 2, 32'h6);
      chkp('{addr: 32'h1, size: 6'h7, burst: 1'b0}, pq[0]);
      chkp('{addr: 32'h8, size: 6'h1, burst: 1'b0}, pq[1]);
      slow <= 1'b0;
      cfg_case(32'h41, 32'h4, 32'h141, 32'h0);
      xfer(32'h0, 6'h10, 2, 32'h4);
      complete_run();
   end
endmodule // testbench
`default_nettype wire
